// ---- design/fcu_compare_unit.sv ----
// single-precision compare unit with sticky status-word flag update
// Function
// - greater-or-equal compare writes 1 when the first source is at least the second, else 0.
// - strictly-greater compare writes 1 only when the first source exceeds the second, else 0.
// - every compare and compare-flag operation completes in 1 cycle in any of 3 issue slots.
// - operands are single-precision floats and the outcome is an integer destination value.
// - a denormal compare operand is taken as zero and sets input-flushed in the status word.
// - an exception raised by a compare sets the matching status-word flag bits.
// - status-word flags are sticky and are cleared only by an explicit status-word write.
// - the status-word flag update lands in the same cycle as the destination write.
// - simultaneous flag updates are ORed together and with the existing flag value.
// - a guarded compare writes destination and flags only when the guard LSB is 1.
// - a compare-flag operation returns the matching compare's exception vector, flags untouched.
// - the vector holds zero-divisor, rounded, too-small, too-large, bad-operand, in/out flushed in bits 0..6.
// - in a compare-flag operation a denormal operand is taken as zero and sets input-flushed.
// - a guarded compare-flag operation writes the destination only when the guard LSB is 1.
// - the equality compare-flag operation returns the equality comparison's exception vector.
// - the greater-or-equal compare-flag operation returns that comparison's exception vector.
`timescale 1ns/1ps
module fcu_compare_unit
   import fcu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire fcu_req_t [FCU_SLOTS-1:0] issue_req,
   input wire logic psw_wr_en,
   input wire logic [FCU_FLAG_W-1:0] psw_wr_flags,
   input wire logic [FCU_FLAG_W-1:0] other_unit_flags,
   output fcu_rsp_t [FCU_SLOTS-1:0] result_rsp,
   output logic [FCU_FLAG_W-1:0] processor_status_word
);

   // decode and flush one operand; denormals become a signed zero
   function automatic fcu_operand_t fcu_classify(input logic [31:0] v);
      fcu_operand_t o;
      logic [7:0] e;
      logic mant_nz;
      e = v[FCU_EXP_HI:FCU_EXP_LO];
      mant_nz = |v[FCU_MANT_HI:0];
      o.sign = v[FCU_SIGN_BIT];
      o.flushed = (e == FCU_EXP_MIN) && mant_nz;
      o.is_nan = (e == FCU_EXP_MAX) && mant_nz;
      o.is_snan = o.is_nan && !v[FCU_QUIET_BIT];
      o.is_zero = (e == FCU_EXP_MIN);
      o.mag = o.is_zero ? 31'h0000_0000 : v[30:0];
      return o;
   endfunction

   // ordered greater-than of two non-NaN operands; both zeros are equal
   function automatic logic fcu_greater(input fcu_operand_t a, input fcu_operand_t b);
      logic g;
      if (a.is_zero && b.is_zero) begin
         g = 1'b0;
      end else if (a.sign != b.sign) begin
         g = !a.sign;
      end else if (!a.sign) begin
         g = a.mag > b.mag;
      end else begin
         g = a.mag < b.mag;
      end
      return g;
   endfunction

   function automatic logic fcu_equal(input fcu_operand_t a, input fcu_operand_t b);
      return (a.is_zero && b.is_zero) || ((a.sign == b.sign) && (a.mag == b.mag));
   endfunction

   // map an opcode to its comparison kind and whether it returns flags
   function automatic logic fcu_decode(input logic [7:0] opc, output fcu_kind_t kind,
                                      output logic flags_op);
      logic known;
      known = 1'b1;
      kind = FCU_KIND_GT;
      flags_op = 1'b0;
      case (opc)
         FCU_OPC_FGTR: begin
            kind = FCU_KIND_GT;
         end
         FCU_OPC_FGTR_FLAGS: begin
            kind = FCU_KIND_GT;
            flags_op = 1'b1;
         end
         FCU_OPC_FGEQ: begin
            kind = FCU_KIND_GE;
         end
         FCU_OPC_FGEQ_FLAGS: begin
            kind = FCU_KIND_GE;
            flags_op = 1'b1;
         end
         FCU_OPC_FEQL_FLAGS: begin
            kind = FCU_KIND_EQ;
            flags_op = 1'b1;
         end
         default: begin
            known = 1'b0;
         end
      endcase
      return known;
   endfunction

   fcu_rsp_t [FCU_SLOTS-1:0] rsp_reg;
   fcu_rsp_t [FCU_SLOTS-1:0] rsp_next;
   logic [FCU_SLOTS-1:0][FCU_FLAG_W-1:0] slot_psw_set;
   logic [FCU_FLAG_W-1:0] psw_reg;
   logic [FCU_FLAG_W-1:0] psw_next;

   genvar gs;
   generate
      for (gs = 0; gs < FCU_SLOTS; gs++) begin : g_slot
         fcu_operand_t a;
         fcu_operand_t b;
         fcu_kind_t kind;
         logic flags_op;
         logic known;
         logic outcome;
         logic any_nan;
         logic [FCU_FLAG_W-1:0] vec;

         always_comb begin
            a = fcu_classify(issue_req[gs].first_source);
            b = fcu_classify(issue_req[gs].second_source);
            known = fcu_decode(issue_req[gs].opcode, kind, flags_op);
            any_nan = a.is_nan || b.is_nan;
            vec = FCU_FLAGS_RESET;
            vec[FCU_INPUT_FLUSHED_BIT] = a.flushed || b.flushed;
            outcome = 1'b0;
            case (kind)
               FCU_KIND_GT: begin
                  outcome = !any_nan && fcu_greater(a, b);
                  vec[FCU_BAD_OPERAND_BIT] = any_nan;
               end
               FCU_KIND_GE: begin
                  outcome = !any_nan && (fcu_greater(a, b) || fcu_equal(a, b));
                  vec[FCU_BAD_OPERAND_BIT] = any_nan;
               end
               FCU_KIND_EQ: begin
                  outcome = !any_nan && fcu_equal(a, b);
                  vec[FCU_BAD_OPERAND_BIT] = a.is_snan || b.is_snan;
               end
               default: begin
                  outcome = 1'b0;
               end
            endcase
            rsp_next[gs].wr_en = issue_req[gs].valid && known
                                 && issue_req[gs].guard_word[0];
            if (flags_op) begin
               rsp_next[gs].data = {25'h000_0000, vec};
            end else begin
               rsp_next[gs].data = outcome ? FCU_TRUE : FCU_FALSE;
            end
            // flag vector operations leave the status word alone
            slot_psw_set[gs] = (rsp_next[gs].wr_en && !flags_op) ? vec
                               : FCU_FLAGS_RESET;
         end
      end
   endgenerate

   // status word: write value, then OR every same-cycle set on top so a set beats a clear
   always_comb begin
      psw_next = psw_wr_en ? psw_wr_flags : psw_reg;
      psw_next = psw_next | other_unit_flags;
      for (int i = 0; i < FCU_SLOTS; i++) begin
         psw_next = psw_next | slot_psw_set[i];
      end
   end

   // one register stage for results and flags, so both land on the same edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < FCU_SLOTS; i++) begin
            rsp_reg[i] <= '{wr_en: 1'b0, data: FCU_DATA_RESET};
         end
         psw_reg <= FCU_FLAGS_RESET;
      end else begin
         rsp_reg <= rsp_next;
         psw_reg <= psw_next;
      end
   end

   assign result_rsp = rsp_reg;
   assign processor_status_word = psw_reg;

endmodule

// ---- design/fcu_pkg.sv ----
// shared constants and carrier types for the float compare unit
package fcu_pkg;

   localparam int FCU_SLOTS = 3;
   localparam int FCU_LATENCY = 1;
   localparam int FCU_DATA_W = 32;
   localparam int FCU_OPC_W = 8;
   localparam int FCU_FLAG_W = 7;

   // operation codes as issued by the pipeline
   localparam logic [7:0] FCU_OPC_FGTR = 8'h90;
   localparam logic [7:0] FCU_OPC_FGTR_FLAGS = 8'h91;
   localparam logic [7:0] FCU_OPC_FGEQ = 8'h92;
   localparam logic [7:0] FCU_OPC_FGEQ_FLAGS = 8'h93;
   localparam logic [7:0] FCU_OPC_FEQL_FLAGS = 8'h95;

   // exception vector bit positions
   localparam int FCU_ZERO_DIVISOR_BIT = 0;
   localparam int FCU_ROUNDED_RESULT_BIT = 1;
   localparam int FCU_TOO_SMALL_BIT = 2;
   localparam int FCU_TOO_LARGE_BIT = 3;
   localparam int FCU_BAD_OPERAND_BIT = 4;
   localparam int FCU_INPUT_FLUSHED_BIT = 5;
   localparam int FCU_OUTPUT_FLUSHED_BIT = 6;

   // single-precision field layout
   localparam int FCU_SIGN_BIT = 31;
   localparam int FCU_EXP_HI = 30;
   localparam int FCU_EXP_LO = 23;
   localparam int FCU_MANT_HI = 22;
   localparam int FCU_QUIET_BIT = 22;
   localparam logic [7:0] FCU_EXP_MAX = 8'hff;
   localparam logic [7:0] FCU_EXP_MIN = 8'h00;

   localparam logic [6:0] FCU_FLAGS_RESET = 7'h00;
   localparam logic [31:0] FCU_DATA_RESET = 32'h0000_0000;
   localparam logic [31:0] FCU_TRUE = 32'h0000_0001;
   localparam logic [31:0] FCU_FALSE = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [31:0] guard_word;
      logic [31:0] first_source;
      logic [31:0] second_source;
   } fcu_req_t;

   typedef struct packed {
      logic wr_en;
      logic [31:0] data;
   } fcu_rsp_t;

   typedef struct packed {
      logic flushed;
      logic is_nan;
      logic is_snan;
      logic is_zero;
      logic sign;
      logic [30:0] mag;
   } fcu_operand_t;

   typedef enum logic [2:0] {
      FCU_KIND_GT = 3'b001,
      FCU_KIND_GE = 3'b010,
      FCU_KIND_EQ = 3'b100
   } fcu_kind_t;

endpackage

// ---- verification/fcu_compare_unit_props.sv ----
// assertion checker for the float compare unit ports
`timescale 1ns/1ps
module fcu_compare_unit_props
   import fcu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire fcu_req_t [FCU_SLOTS-1:0] issue_req,
   input wire logic psw_wr_en,
   input wire logic [FCU_FLAG_W-1:0] psw_wr_flags,
   input wire logic [FCU_FLAG_W-1:0] other_unit_flags,
   input wire fcu_rsp_t [FCU_SLOTS-1:0] result_rsp,
   input wire logic [FCU_FLAG_W-1:0] processor_status_word
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire fcu_req_t r0 = issue_req[0];
   wire fcu_rsp_t o0 = result_rsp[0];
   wire logic [6:0] psw = processor_status_word;
   sequence go_s(logic [7:0] op);
      r0.valid && r0.guard_word[0] && r0.opcode == op;
   endsequence
   lat_ge_a: assert property (go_s(FCU_OPC_FGEQ) |=> o0.wr_en && o0.data[31:1] == 31'h0)
      else $error("compare answer missing");
   lat_fl_a: assert property (go_s(FCU_OPC_FEQL_FLAGS) |=> o0.wr_en && o0.data[31:7] == 25'h0)
      else $error("flag answer malformed");
   guard_a: assert property (r0.valid && !r0.guard_word[0] |=> !o0.wr_en)
      else $error("false guard wrote");
   nan_a: assert property (go_s(FCU_OPC_FGEQ) ##0 r0.second_source == 32'h7fffffff |=>
      o0.data == FCU_FALSE && psw[4]) else $error("nan compare wrong");
   flagop_a: assert property (go_s(FCU_OPC_FGEQ_FLAGS) ##0 r0.second_source == 32'h00400000 |=>
      o0.data[5]) else $error("flush bit missing");
   den_psw_a: assert property (go_s(FCU_OPC_FGEQ) ##0 r0.second_source == 32'h00400000 |=> psw[5])
      else $error("flush flag missing");
   sticky_a: assert property (!psw_wr_en |=> (psw & $past(psw)) == $past(psw))
      else $error("flag lost");
   or_in_a: assert property ((psw & $past(other_unit_flags)) == $past(other_unit_flags))
      else $error("other flags lost");
   low_bits_a: assert property (!psw_wr_en |=>
      (psw & 7'h0f) == (($past(psw) | $past(other_unit_flags)) & 7'h0f)) else $error("stray flag");
endmodule
bind fcu_compare_unit fcu_compare_unit_props chk (.clock(clock), .rst_n(rst_n),
   .issue_req(issue_req), .psw_wr_en(psw_wr_en), .psw_wr_flags(psw_wr_flags),
   .other_unit_flags(other_unit_flags), .result_rsp(result_rsp),
   .processor_status_word(processor_status_word));

// ---- verification/fcu_dest_model.sv ----
// register file model that takes the unit's destination writes
`timescale 1ns/1ps
module fcu_dest_model
   import fcu_pkg::*;
(
   input wire logic clock,
   input wire fcu_rsp_t [FCU_SLOTS-1:0] result_rsp,
   output logic [FCU_SLOTS-1:0][31:0] dest
);
   always_ff @(posedge clock) begin
      for (int s = 0; s < FCU_SLOTS; s++) begin
         if (result_rsp[s].wr_en) begin
            dest[s] <= result_rsp[s].data;
         end
      end
   end
endmodule

// ---- verification/test_fcu_compare_unit.sv ----
// self-checking bench for the float compare unit
`timescale 1ns/1ps
module test_fcu_compare_unit
   import fcu_pkg::*;
   ;
   logic clock = 0;
   logic rst_n = 0;
   fcu_req_t [FCU_SLOTS-1:0] issue_req = '0;
   logic psw_wr_en = 0;
   logic [6:0] psw_wr_flags = '0;
   logic [6:0] other_unit_flags = '0;
   fcu_rsp_t [FCU_SLOTS-1:0] result_rsp;
   logic [6:0] processor_status_word;
   logic [FCU_SLOTS-1:0][31:0] dest;
   logic [6:0] pe = '0;
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   // opcode, first, second, expected data, expected new status flags
   logic [87:0] tab [17] = '{88'h93_40400000_7fffffff_10_00, 88'h93_3f800000_00400000_20_00,
      88'h93_40400000_3f800000_00_00, 88'h91_40400000_7fffffff_10_00,
      88'h95_40400000_7fffffff_00_00, 88'h95_3f800000_00400000_20_00,
      88'h95_7fa00000_7fa00000_10_00, 88'h92_40400000_00000000_01_00,
      88'h92_40400000_40400000_01_00, 88'h92_3f800000_40400000_00_00,
      88'h92_7f800000_ff800000_01_00, 88'h92_3f800000_00400000_01_20,
      88'h92_40400000_7fffffff_00_10, 88'h90_40400000_40400000_00_00,
      88'h90_40400000_3f800000_01_00, 88'h90_7f800000_7f800000_00_00,
      88'h90_3f800000_00400000_01_20};
   always #2.5 clock = ~clock;
   fcu_compare_unit dut (.clock(clock), .rst_n(rst_n), .issue_req(issue_req),
      .psw_wr_en(psw_wr_en), .psw_wr_flags(psw_wr_flags), .other_unit_flags(other_unit_flags),
      .result_rsp(result_rsp), .processor_status_word(processor_status_word));
   fcu_dest_model regs (.clock(clock), .result_rsp(result_rsp), .dest(dest));
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task set(input int s, input logic [7:0] o, input logic g, input logic [31:0] a, b);
      issue_req[s] <= '{1'b1, o, {31'h0, g}, a, b};
   endtask
   // the taking edge, then let the registered answer settle
   task step;
      @(posedge clock);
      for (int s = 0; s < FCU_SLOTS; s++) issue_req[s].valid <= 1'b0;
      psw_wr_en <= 1'b0;
      other_unit_flags <= '0;
      #1;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         mismatches++;
         final_report;
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      foreach (tab[i]) begin
         @(posedge clock);
         set(0, tab[i][87:80], 1'b1, tab[i][79:48], tab[i][47:16]);
         step;
         pe = pe | tab[i][6:0];
         chk("wr_en", 32'h1, result_rsp[0].wr_en);
         chk("data", tab[i][15:8], result_rsp[0].data);
         chk("psw", pe, processor_status_word);
      end
      @(posedge clock);
      set(1, FCU_OPC_FGEQ, 1'b1, 32'h40400000, 32'h7fffffff);
      psw_wr_en <= 1'b1;
      other_unit_flags <= 7'h41;
      step;
      chk("psw", 32'h51, processor_status_word);
      chk("slot1", 32'h1, result_rsp[1].wr_en);
      @(posedge clock);
      psw_wr_en <= 1'b1;
      psw_wr_flags <= 7'h02;
      step;
      chk("psw", 32'h02, processor_status_word);
      @(posedge clock);
      set(0, FCU_OPC_FGEQ, 1'b0, 32'h40400000, 32'h7fffffff);
      set(1, 8'h94, 1'b1, 32'h40400000, 32'h7fffffff);
      set(2, FCU_OPC_FGTR, 1'b1, 32'h40400000, 32'h3f800000);
      step;
      chk("refused", 32'h0, {result_rsp[1].wr_en, result_rsp[0].wr_en});
      chk("slot2", 32'h1, result_rsp[2].data);
      chk("psw", 32'h02, processor_status_word);
      @(posedge clock);
      set(2, FCU_OPC_FGTR_FLAGS, 1'b0, 32'h40400000, 32'h7fffffff);
      step;
      chk("flag_guard", 32'h0, result_rsp[2].wr_en);
      @(posedge clock);
      #1;
      chk("dest", 32'h1, dest[0]);
      chk("dest2", 32'h1, dest[2]);
      final_report;
   end
endmodule
